// ---- rtl/ipc_pkg.sv ----
// Purpose: Shared constants and types of the idle and wake-up power control block
// Assumes: 10 MHz core clock, APB register access, SPI-style command link
// Notes:   Frame bytes, wake codes and control words are the device's own values
package ipc_pkg;

  // Clock and timing
  localparam int unsigned CLK_FREQ_HZ  = 10_000_000;
  localparam int unsigned BOOT_TIME_US = 6000;
  localparam int unsigned BOOT_CYCLES  = BOOT_TIME_US * (CLK_FREQ_HZ / 1_000_000);

  // Command frame bytes
  localparam logic [7:0] CMD_IDLE     = 8'h07;
  localparam logic [7:0] LEN_IDLE     = 8'h0e;
  localparam logic [7:0] IDLE_BYTES   = 8'h10;
  localparam logic [7:0] RES_OK       = 8'h00;
  localparam logic [7:0] RES_LEN_WAKE = 8'h01;
  localparam logic [7:0] ERR_LEN      = 8'h82;
  localparam logic [7:0] ERR_LEN_DATA = 8'h00;
  localparam logic [1:0] RESP_WAKE_N  = 2'h3;
  localparam logic [1:0] RESP_ERR_N   = 2'h2;

  // Wake-up source byte
  localparam logic [7:0] WSRC_FIELD    = 8'h04;
  localparam logic [7:0] WSRC_PIN      = 8'h08;
  localparam int unsigned WSRC_FLD_BIT = 2;
  localparam int unsigned WSRC_ALT_BIT = 1;
  localparam int unsigned WSRC_PIN_BIT = 3;

  // Control words
  localparam logic [15:0] ENT_HIBER    = 16'h0400;
  localparam logic [15:0] ENT_SLEEP_FD = 16'h0142;
  localparam logic [15:0] ENT_SLEEP    = 16'h0100;
  localparam logic [15:0] WUC_HIBER    = 16'h0400;
  localparam logic [15:0] WUC_SLEEP    = 16'h3800;
  localparam logic [15:0] EXIT_DEFAULT = 16'h1800;

  // APB byte offsets
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_STATUS   = 8'h04;
  localparam logic [7:0] ADDR_WSRC     = 8'h08;
  localparam logic [7:0] ADDR_ENTRY    = 8'h0c;
  localparam logic [7:0] ADDR_WAKEUP   = 8'h10;
  localparam logic [7:0] ADDR_EXIT     = 8'h14;
  localparam logic [7:0] ADDR_INT_STAT = 8'h18;
  localparam logic [7:0] ADDR_INT_MASK = 8'h1c;

  // Field positions and reset values
  localparam int unsigned CTRL_CMD_EN_BIT = 0;
  localparam int unsigned CTRL_FORCE_BIT  = 1;
  localparam logic        CTRL_CMD_EN_RST = 1'h1;
  localparam logic [3:0]  INT_MASK_RST    = 4'h0;
  localparam int unsigned INT_IDLE_BIT    = 0;
  localparam int unsigned INT_WAKE_BIT    = 1;
  localparam int unsigned INT_ERR_BIT     = 2;
  localparam int unsigned INT_READY_BIT   = 3;
  localparam int unsigned STAT_PEND_BIT   = 3;
  localparam int unsigned STAT_CAUSE_LSB  = 8;
  localparam logic [4:0]  PIN_RST         = 5'h0a;

  // Power states
  typedef enum logic [2:0] {PS_PWRUP, PS_BOOT, PS_READY, PS_SLEEP, PS_HIBER} ipc_pstate_type;

endpackage

// ---- rtl/ipc_pin_sync.sv ----
// Purpose: Three-stage synchroniser for pins from outside the core clock domain
// Assumes: Inputs change slowly against CORE clock
// Notes:   Output follows only once stages two and three agree
module ipc_pin_sync #(
  parameter int unsigned    W       = 1,
  parameter logic [W-1:0]   RST_VAL = '0
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] pin_i,
  output logic      [W-1:0] lvl_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
  } ipc_sync_type;

  ipc_sync_type st_r, st_nxt;
  logic [W-1:0] agree;

  // Stage one feeds stage two only; the filter looks at two and three
  always_comb begin
    st_nxt    = st_r;
    agree     = ~(st_r.s2 ^ st_r.s3);
    st_nxt.s1 = pin_i;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    st_nxt.lvl = (st_r.s3 & agree) | (st_r.lvl & ~agree);
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r <= {RST_VAL, RST_VAL, RST_VAL, RST_VAL};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign lvl_o = st_r.lvl;
endmodule

// ---- rtl/ipc_link_shift.sv ----
// Purpose: Byte shifter for the serial command link, mode 0, MSB first
// Assumes: Link clock and select already synchronised to the core clock
// Notes:   Link clock period must be at least eight core clock periods
module ipc_link_shift (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  // Clean link levels
  input  wire logic       sck_i,
  input  wire logic       cs_n_i,
  input  wire logic       mosi_i,
  // Byte side
  input  wire logic [7:0] tx_byte_i,
  output logic      [7:0] rx_byte_o,
  output logic            rx_valid_o,
  output logic            frame_start_o,
  output logic            frame_end_o,
  // Reply pin
  output logic            miso_o,
  output logic            miso_oe_o
);
  typedef struct packed {
    logic       sck_q;
    logic       cs_q;
    logic [7:0] rx_sh;
    logic [2:0] bit_cnt;
    logic [7:0] tx_sh;
    logic [7:0] rx_byte;
    logic       rx_valid;
    logic       fstart;
    logic       fend;
    logic       miso;
    logic       oe;
    logic [1:0] reload;
  } ipc_shift_type;

  ipc_shift_type st_r, n;

  // Edge finding on the clean levels. The reply shifts just after each rise, not on the
  // fall: sync delay is half a link period, so a fall-timed change would meet the next rise.
  // The next reply byte loads two cycles after the eighth rise, once its index has moved on
  always_comb begin
    n          = st_r;
    n.sck_q    = sck_i;
    n.cs_q     = cs_n_i;
    n.rx_valid = 1'b0;
    n.reload   = {st_r.reload[0], 1'b0};
    n.fstart   = st_r.cs_q & ~cs_n_i;
    n.fend     = ~st_r.cs_q & cs_n_i;
    if (n.fstart) begin
      n.bit_cnt = 3'h0;
      n.tx_sh   = tx_byte_i;
    end else if (!cs_n_i && !st_r.sck_q && sck_i) begin
      n.rx_sh   = {st_r.rx_sh[6:0], mosi_i};
      n.bit_cnt = st_r.bit_cnt + 3'h1;
      if (st_r.bit_cnt == 3'h7) begin
        n.rx_byte   = {st_r.rx_sh[6:0], mosi_i};
        n.rx_valid  = 1'b1;
        n.reload[0] = 1'b1;
      end else begin
        n.tx_sh = {st_r.tx_sh[6:0], 1'b0};
      end
    end else if (st_r.reload[1]) begin
      n.tx_sh = tx_byte_i;
    end
    n.miso = n.tx_sh[7];
    n.oe   = ~cs_n_i;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r <= '{sck_q: 1'b0, cs_q: 1'b1, default: '0};
    end else begin
      st_r <= n;
    end
  end

  assign rx_byte_o     = st_r.rx_byte;
  assign rx_valid_o    = st_r.rx_valid;
  assign frame_start_o = st_r.fstart;
  assign frame_end_o   = st_r.fend;
  assign miso_o        = st_r.miso;
  assign miso_oe_o     = st_r.oe;
endmodule

// ---- rtl/ipc_idle_power_ctrl.sv ----
// Purpose: Idle command decode, low-power wait states and wake-up reporting
// Assumes: APB master on the core clock; link pins asynchronous to it
// Notes:   Commands other than idle are left to neighbouring blocks
//
// Design decisions made here: the register addresses and the APB slave port.

module ipc_idle_power_ctrl
  import ipc_pkg::*;
#(
  parameter int unsigned BOOT_CNT = BOOT_CYCLES,
  parameter int unsigned AW       = 8
) (
  // Clock and reset
  input  wire logic          CORE_CLK_I,
  input  wire logic          RST_N_I,
  // APB slave
  input  wire logic          PSEL_I,
  input  wire logic          PENABLE_I,
  input  wire logic          PWRITE_I,
  input  wire logic [AW-1:0] PADDR_I,
  input  wire logic [31:0]   PWDATA_I,
  output logic      [31:0]   PRDATA_O,
  output logic               PREADY_O,
  output logic               PSLVERR_O,
  // Serial command link
  input  wire logic          SPI_SCK_I,
  input  wire logic          SPI_CS_N_I,
  input  wire logic          SPI_MOSI_I,
  output logic               SPI_MISO_O,
  output logic               SPI_MISO_OE_O,
  // Wake sources
  input  wire logic          WAKE_N_I,
  input  wire logic          FIELD_DET_I,
  // Power and status
  output logic               FIELD_DET_EN_O,
  output logic               CORE_ON_O,
  output logic               SPI_SEL_O,
  output logic               RESP_RDY_O,
  output logic               IRQ_O
);
  localparam int unsigned BCW = $clog2(BOOT_CNT + 1);

  typedef struct packed {
    ipc_pstate_type  pstate;
    logic [BCW-1:0]  boot_cnt;
    logic [7:0]      bcnt;
    logic [7:0]      code;
    logic [7:0]      len;
    logic [7:0]      wsrc;
    logic [15:0]     ent;
    logic [15:0]     wuc;
    logic [15:0]     exc;
    logic            resp_pend;
    logic [1:0]      resp_n;
    logic [1:0]      tx_idx;
    logic [0:2][7:0] resp;
    logic [7:0]      cause;
    logic            cmd_en;
    logic            force_wk;
    logic [3:0]      istat;
    logic [3:0]      imask;
    logic            wake_q;
    logic [31:0]     prdata;
    logic            pready;
    logic            pslverr;
    logic            fld_en;
    logic            core_on;
    logic            spi_sel;
    logic            irq;
  } ipc_state_type;

  ipc_state_type st, n;

  logic [4:0] pin_lvl;
  logic       sck_l;
  logic       cs_n_l;
  logic       mosi_l;
  logic       wake_l;
  logic       field_l;
  logic [7:0] rx_byte;
  logic       rx_valid;
  logic       f_start;
  logic       f_end;
  logic [7:0] tx_byte;
  logic       pin_fall;
  logic       idle_go;
  logic       len_err;
  logic       fld_src;
  logic       apb_done;
  logic [7:0] addr;
  logic [3:0] ev_set;
  logic [3:0] ev_clr;

  // All asynchronous pins share one synchroniser
  ipc_pin_sync #(
    .W       (5),
    .RST_VAL (PIN_RST)
  ) u_sync (
    .clk_i   (CORE_CLK_I),
    .rst_n_i (RST_N_I),
    .pin_i   ({SPI_SCK_I, SPI_CS_N_I, SPI_MOSI_I, WAKE_N_I, FIELD_DET_I}),
    .lvl_o   (pin_lvl)
  );

  assign {sck_l, cs_n_l, mosi_l, wake_l, field_l} = pin_lvl;

  ipc_link_shift u_shift (
    .clk_i         (CORE_CLK_I),
    .rst_n_i       (RST_N_I),
    .sck_i         (sck_l),
    .cs_n_i        (cs_n_l),
    .mosi_i        (mosi_l),
    .tx_byte_i     (tx_byte),
    .rx_byte_o     (rx_byte),
    .rx_valid_o    (rx_valid),
    .frame_start_o (f_start),
    .frame_end_o   (f_end),
    .miso_o        (SPI_MISO_O),
    .miso_oe_o     (SPI_MISO_OE_O)
  );

  // Reply bytes go out by index; past the end the link reads zero
  assign tx_byte = (st.resp_pend && st.tx_idx < st.resp_n) ? st.resp[st.tx_idx] : 8'h00;

  // Whole next state of the block
  always_comb begin
    n        = st;
    idle_go  = 1'b0;
    len_err  = 1'b0;
    ev_set   = 4'h0;
    ev_clr   = 4'h0;
    addr     = 8'(PADDR_I);
    pin_fall = st.wake_q & ~wake_l;
    fld_src  = st.wsrc[WSRC_FLD_BIT] | st.wsrc[WSRC_ALT_BIT];
    apb_done = PSEL_I & PENABLE_I & st.pready;
    n.wake_q   = wake_l;
    n.force_wk = 1'b0;

    // APB answers one cycle after setup, so read data is always registered
    n.pready  = PSEL_I & ~PENABLE_I;
    n.pslverr = 1'b0;
    if (PSEL_I && !PENABLE_I) begin
      n.prdata = 32'h0;
      if (addr == ADDR_CTRL) begin
        n.prdata[CTRL_CMD_EN_BIT] = st.cmd_en;
      end else if (addr == ADDR_STATUS) begin
        n.prdata[2:0]                         = st.pstate;
        n.prdata[STAT_PEND_BIT]               = st.resp_pend;
        n.prdata[STAT_CAUSE_LSB+:8]           = st.cause;
      end else if (addr == ADDR_WSRC) begin
        n.prdata[7:0] = st.wsrc;
      end else if (addr == ADDR_ENTRY) begin
        n.prdata[15:0] = st.ent;
      end else if (addr == ADDR_WAKEUP) begin
        n.prdata[15:0] = st.wuc;
      end else if (addr == ADDR_EXIT) begin
        n.prdata[15:0] = st.exc;
      end else if (addr == ADDR_INT_STAT) begin
        n.prdata[3:0] = st.istat;
      end else if (addr == ADDR_INT_MASK) begin
        n.prdata[3:0] = st.imask;
      end else begin
        n.pslverr = 1'b1;
      end
    end
    if (apb_done && PWRITE_I) begin
      if (addr == ADDR_CTRL) begin
        n.cmd_en   = PWDATA_I[CTRL_CMD_EN_BIT];
        n.force_wk = PWDATA_I[CTRL_FORCE_BIT];
      end else if (addr == ADDR_INT_MASK) begin
        n.imask = PWDATA_I[3:0];
      end
    end else if (apb_done && addr == ADDR_INT_STAT) begin
      ev_clr = st.istat;
    end

    // Link bytes: replies are drained first, commands only when ready
    if (f_start) begin
      n.bcnt   = 8'h00;
      n.tx_idx = 2'h0;
    end
    if (rx_valid && st.resp_pend) begin
      n.tx_idx = (st.tx_idx == 2'h3) ? st.tx_idx : st.tx_idx + 2'h1;
    end else if (rx_valid && st.pstate == PS_READY && st.cmd_en) begin
      n.bcnt = (st.bcnt == 8'hff) ? st.bcnt : st.bcnt + 8'h01;
      case (st.bcnt)
        8'h00: n.code = rx_byte;
        8'h01: n.len = rx_byte;
        8'h02: n.wsrc = rx_byte;
        8'h03: n.ent[7:0] = rx_byte;
        8'h04: n.ent[15:8] = rx_byte;
        8'h05: n.wuc[7:0] = rx_byte;
        8'h06: n.wuc[15:8] = rx_byte;
        8'h07: n.exc[7:0] = rx_byte;
        8'h08: n.exc[15:8] = rx_byte;
        default: n.bcnt = n.bcnt;
      endcase
    end
    if (f_end && st.resp_pend) begin
      // A partly read reply stays pending so the host may fetch it again
      if (st.tx_idx >= st.resp_n) begin
        n.resp_pend = 1'b0;
      end
      n.tx_idx = 2'h0;
    end else if (f_end && st.pstate == PS_READY && st.cmd_en && st.bcnt != 8'h00
                 && st.code == CMD_IDLE) begin
      if (st.len == LEN_IDLE && st.bcnt == IDLE_BYTES) begin
        idle_go = 1'b1;
      end else begin
        len_err = 1'b1;
      end
    end

    // Error reply for a malformed idle frame
    if (len_err) begin
      n.resp      = {ERR_LEN, ERR_LEN_DATA, 8'h00};
      n.resp_n    = RESP_ERR_N;
      n.resp_pend = 1'b1;
      ev_set[INT_ERR_BIT] = 1'b1;
    end

    // Power state sequence
    case (st.pstate)
      PS_PWRUP: begin
        if (pin_fall || st.force_wk) begin
          n.pstate   = PS_BOOT;
          n.boot_cnt = BCW'(BOOT_CNT - 1);
        end
      end
      PS_BOOT: begin
        if (st.boot_cnt == '0) begin
          n.pstate = PS_READY;
          ev_set[INT_READY_BIT] = 1'b1;
        end else begin
          n.boot_cnt = st.boot_cnt - BCW'(1);
        end
      end
      PS_READY: begin
        if (idle_go) begin
          // Either word asking for hibernate wins, as it is the safer state
          if (st.ent == ENT_HIBER || st.wuc == WUC_HIBER) begin
            n.pstate = PS_HIBER;
          end else begin
            n.pstate = PS_SLEEP;
          end
          ev_set[INT_IDLE_BIT] = 1'b1;
        end
      end
      PS_SLEEP: begin
        if ((pin_fall && st.wsrc[WSRC_PIN_BIT]) || st.force_wk) begin
          n.pstate = PS_READY;
          n.cause  = WSRC_PIN;
        end else if (fld_src && field_l) begin
          n.pstate = PS_READY;
          n.cause  = WSRC_FIELD;
        end
      end
      PS_HIBER: begin
        // Field level is not even looked at here
        if (pin_fall || st.force_wk) begin
          n.pstate = PS_READY;
          n.cause  = WSRC_PIN;
        end
      end
      default: n.pstate = PS_PWRUP;
    endcase

    // Wake reply is built only on the way out of a wait state
    if ((st.pstate == PS_SLEEP || st.pstate == PS_HIBER) && n.pstate == PS_READY) begin
      n.resp      = {RES_OK, RES_LEN_WAKE, n.cause};
      n.resp_n    = RESP_WAKE_N;
      n.resp_pend = 1'b1;
      n.tx_idx    = 2'h0;
      ev_set[INT_WAKE_BIT] = 1'b1;
    end

    // Sticky events: a new event beats a read clear in the same cycle
    n.istat = (st.istat & ~ev_clr) | ev_set;

    // Resource enables follow the next state
    n.fld_en  = (n.pstate == PS_SLEEP) && (n.wsrc[WSRC_FLD_BIT] | n.wsrc[WSRC_ALT_BIT]);
    n.core_on = (n.pstate == PS_READY) || (n.pstate == PS_BOOT);
    n.spi_sel = (n.pstate != PS_PWRUP);
    n.irq     = |(n.istat & n.imask);
  end

  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      st <= '{pstate: PS_PWRUP, exc: EXIT_DEFAULT, cmd_en: CTRL_CMD_EN_RST,
              imask: INT_MASK_RST, wake_q: 1'b1, default: '0};
    end else begin
      st <= n;
    end
  end

  // Top outputs straight from the state register
  assign PRDATA_O       = st.prdata;
  assign PREADY_O       = st.pready;
  assign PSLVERR_O      = st.pslverr;
  assign FIELD_DET_EN_O = st.fld_en;
  assign CORE_ON_O      = st.core_on;
  assign SPI_SEL_O      = st.spi_sel;
  assign RESP_RDY_O     = st.resp_pend;
  assign IRQ_O          = st.irq;

  // Checks on the sequence
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RST_N_I);

  AST_IDLE_ENTERS_WAIT: assert property (
    idle_go |=> (st.pstate == PS_SLEEP || st.pstate == PS_HIBER) && !st.resp_pend)
    else $error("idle frame did not enter a wait state");
  AST_ENTRY_LOW_FIRST: assert property (
    (rx_valid && st.pstate == PS_READY && st.cmd_en && !st.resp_pend && st.bcnt == 8'h03)
    |=> st.ent[7:0] == $past(rx_byte))
    else $error("entry low byte not taken from fourth byte");
  AST_FIELD_ENABLE: assert property (
    st.pstate == PS_SLEEP |-> st.fld_en == (st.wsrc[2] | st.wsrc[1]))
    else $error("field detector enable does not follow source byte");
  AST_HIBER_SELECT: assert property (
    (idle_go && st.ent == ENT_HIBER) |=> st.pstate == PS_HIBER)
    else $error("hibernate entry word not honoured");
  AST_WAKE_REPLY: assert property (
    (st.pstate inside {PS_SLEEP, PS_HIBER}) ##1 (st.pstate == PS_READY)
    |-> st.resp_pend && st.resp[0] == 8'h00 && st.resp[1] == 8'h01
        && (st.resp[2] == 8'h04 || st.resp[2] == 8'h08))
    else $error("wake reply missing or malformed");
  AST_HIBER_NO_FIELD: assert property (
    (st.pstate == PS_HIBER && !pin_fall && !st.force_wk) |=> st.pstate == PS_HIBER)
    else $error("hibernate left without pin pulse");
  AST_PWRUP_HOLDS: assert property (
    (st.pstate == PS_PWRUP && !pin_fall && !st.force_wk) |=> st.pstate == PS_PWRUP)
    else $error("power-up left without pin pulse");
  AST_BOOT_WAIT: assert property (
    (st.pstate == PS_BOOT && st.boot_cnt != '0) |=> st.pstate == PS_BOOT)
    else $error("ready reached before boot delay ran out");
  AST_LEN_ERROR: assert property (
    len_err |=> st.resp_pend && st.resp[0] == 8'h82 && st.resp[1] == 8'h00 && st.core_on)
    else $error("bad idle length gave no error reply");

  COV_SLEEP_FIELD: cover property (st.pstate == PS_SLEEP && fld_src && field_l ##1
                                   st.pstate == PS_READY);
  COV_HIBER_PIN: cover property (st.pstate == PS_HIBER ##1 st.pstate == PS_READY);
  COV_LEN_ERR: cover property (len_err);
  COV_BOOT_DONE: cover property (st.pstate == PS_BOOT ##1 st.pstate == PS_READY);
endmodule

// ---- dv/ipc_host_model.sv ----
// Purpose: Host side of the serial command link, mode 0, MSB first
// Assumes: 800 ns link clock made here, unrelated to the core clock
// Notes:   Link clock stands still between frames
module ipc_host_model (
  // Device reply
  input  wire logic miso_i,
  input  wire logic miso_oe_i,
  // Link outputs
  output logic      sck_o,
  output logic      cs_n_o,
  output logic      mosi_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] rx_q [16];

  // Idle levels at time zero
  initial begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end

  // Released data line keeps changing so no stale bit can pass for data
  always #397 if (cs_n_o) mosi_o = ~mosi_o;

  // One frame of n bytes; a bit of an undriven reply line is kept unknown
  task automatic xfer(input logic [7:0] tx [16], input int n);
    int i;
    int b;
    cs_n_o = 1'b0;
    #800;
    for (i = 0; i < n; i++) begin
      for (b = 7; b >= 0; b--) begin
        mosi_o = tx[i][b];
        #400 sck_o = 1'b1;
        rx_q[i][b] = miso_oe_i ? miso_i : 1'bx;
        #400 sck_o = 1'b0;
      end
    end
    #400 cs_n_o = 1'b1;
    #1200;
  endtask
endmodule

// ---- dv/testbench.sv ----
// Purpose: Self-checking bench for the idle and wake-up power control block
// Assumes: Boot count shortened to 20 cycles; host model drives the link
// Notes:   Pad bytes and extra source bits are random from a fixed seed
module testbench import ipc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, rst_n, psel, penable, pwrite, wake_n, field, err;
  logic        pready, pslverr, sck, cs_n, mosi, miso, miso_oe;
  logic        fd_en, core_on, spi_sel, resp_rdy, irq;
  logic [7:0]  paddr, src;
  logic [2:0]  st;
  logic [31:0] pwdata, prdata, d;
  logic [7:0]  frm [16];
  int          mismatches, compares, cyc;
  logic [15:0] ent_t [3] = '{16'h0400, 16'h0142, 16'h0100};
  logic [15:0] wuc_t [3] = '{16'h0400, 16'h3800, 16'h3800};

  ipc_idle_power_ctrl #(.BOOT_CNT(20), .AW(8)) uut (
    .CORE_CLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .SPI_SCK_I(sck), .SPI_CS_N_I(cs_n),
    .SPI_MOSI_I(mosi), .SPI_MISO_O(miso), .SPI_MISO_OE_O(miso_oe), .WAKE_N_I(wake_n),
    .FIELD_DET_I(field), .FIELD_DET_EN_O(fd_en), .CORE_ON_O(core_on),
    .SPI_SEL_O(spi_sel), .RESP_RDY_O(resp_rdy), .IRQ_O(irq));

  ipc_host_model host (.miso_i(miso), .miso_oe_i(miso_oe), .sck_o(sck), .cs_n_o(cs_n),
    .mosi_o(mosi));

  // 10 MHz core clock
  always #50 clk = ~clk;

  // Hang guard, well above the few thousand cycles the run needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      mismatches++;
      tally_and_finish;
    end
  end

  task automatic tally_and_finish;
    if (mismatches == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; request held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    // Answer is looked at mid-cycle, where it has settled; it stands up to the next edge
    @(negedge clk);
    while (pready !== 1'b1) @(negedge clk);
    d = prdata;
    err = pslverr;
    @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask

  task automatic wait_state(input logic [2:0] s);
    int k;
    k = 0;
    rd(ADDR_STATUS);
    while (d[2:0] !== s && k < 100) begin
      rd(ADDR_STATUS);
      k++;
    end
    chk(d[2:0], s);
  endtask

  task automatic wait_resp;
    int k;
    k = 0;
    while (resp_rdy !== 1'b1 && k < 200) begin
      @(negedge clk);
      k++;
    end
    chk(resp_rdy, 1'b1);
  endtask

  // Wake pin low for six cycles, above the two the sync needs
  task automatic pulse;
    @(posedge clk);
    wake_n <= 1'b0;
    repeat (6) @(posedge clk);
    wake_n <= 1'b1;
  endtask

  task automatic send(input logic [7:0] c, input logic [7:0] l, input logic [7:0] s,
                      input logic [15:0] e, input logic [15:0] w);
    frm[0] = c;
    frm[1] = l;
    frm[2] = s;
    frm[3] = e[7:0];
    frm[4] = e[15:8];
    frm[5] = w[7:0];
    frm[6] = w[15:8];
    frm[7] = 8'h00;
    frm[8] = 8'h18;
    for (int i = 9; i < 16; i++) frm[i] = 8'($urandom);
    host.xfer(frm, 16);
  endtask

  function automatic logic [2:0] exp_state(input logic [15:0] e, input logic [15:0] w);
    return (e == 16'h0400 || w == 16'h0400) ? 3'h4 : 3'h3;
  endfunction

  function automatic logic exp_fden(input logic [2:0] s, input logic [7:0] v);
    return s == 3'h3 && (v[2] || v[1]);
  endfunction

  // Main sequence
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    wake_n = 1'b1;
    field = 1'b0;
    {mismatches, compares, cyc} = '0;
    void'($urandom(32'h08a36238));
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rd(ADDR_EXIT);
    chk(d, 32'h1800);
    rd(8'h40);
    chk({err, d[30:0]}, 32'h80000000);
    rd(ADDR_STATUS);
    chk({spi_sel, core_on, d[2:0]}, 5'h0);
    pulse;
    wait_state(3'h2);
    chk({spi_sel, core_on, resp_rdy, irq}, 4'hc);
    rd(ADDR_INT_STAT);
    chk(d[3], 1'b1);
    apb(1'b1, ADDR_INT_MASK, 32'h5);
    send(8'h06, LEN_IDLE, 8'h08, 16'h0400, 16'h0400);
    wait_state(3'h2);
    send(8'h07, 8'h0d, 8'h08, 16'h0400, 16'h0400);
    wait_resp;
    chk(irq, 1'b1);
    frm = '{default: 8'h00};
    host.xfer(frm, 2);
    chk({host.rx_q[0], host.rx_q[1]}, 16'h8200);
    rd(ADDR_INT_STAT);
    repeat (2) @(posedge clk);
    chk({d[2], irq}, 2'h2);
    // With command decode switched off a valid idle frame is ignored
    apb(1'b1, ADDR_CTRL, 32'h0);
    send(8'h07, LEN_IDLE, 8'h08, 16'h0400, 16'h0400);
    wait_state(3'h2);
    apb(1'b1, ADDR_CTRL, 32'h1);
    for (int i = 0; i < 3; i++) begin
      src = (i == 1) ? 8'h04 : 8'h08 | ((i == 2) ? 8'($urandom & 32'h6) : 8'h0);
      st = exp_state(ent_t[i], wuc_t[i]);
      send(8'h07, 8'h0e, src, ent_t[i], wuc_t[i]);
      wait_state(st);
      chk({core_on, fd_en, irq}, {1'b0, exp_fden(st, src), 1'b1});
      // Frame fields land in their registers, words low byte first
      rd(ADDR_WSRC);
      chk(d, {24'h0, src});
      rd(ADDR_ENTRY);
      chk(d, {16'h0, ent_t[i]});
      rd(ADDR_WAKEUP);
      chk(d, {16'h0, wuc_t[i]});
      rd(ADDR_INT_STAT);
      if (i != 2) begin
        field <= 1'b1;
        repeat (30) @(posedge clk);
      end
      if (i == 0) begin
        rd(ADDR_STATUS);
        chk({d[2:0], resp_rdy}, 4'h8);
        field <= 1'b0;
      end
      if (i != 1) pulse;
      wait_resp;
      field <= 1'b0;
      frm = '{default: 8'h00};
      host.xfer(frm, 3);
      chk({host.rx_q[0], host.rx_q[1]}, 16'h0001);
      if (i != 0) chk(host.rx_q[2], (i == 1) ? 8'h04 : 8'h08);
      chk(resp_rdy, 1'b0);
      wait_state(3'h2);
    end
    // Mid-run reset puts the block back in power-up with link and core off
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rd(ADDR_STATUS);
    chk({spi_sel, core_on, irq, d[2:0]}, 6'h0);
    tally_and_finish;
  end
endmodule
